// File: rtl/acs_pkg.sv
// Shared constants and carrier types for the acquire/convert sequencer
package acs_pkg;

    // Acquisition phase lengths in master clock cycles
    localparam int unsigned COARSE_CYC = 6;
    localparam int unsigned FINE_CYC = 9;

    // End-of-conversion strobe length and hold recognition divider
    localparam int unsigned EOC_CYC = 4;
    localparam int unsigned HOLD_DIV = 4;

    // Default result width
    localparam int unsigned RES_W = 16;

    // Width of the phase and strobe counters
    localparam int unsigned CNT_W = 4;

    // Reset values of the pin-side outputs (all strobes idle high)
    localparam logic TRACK_DONE_RST = 1'b1;
    localparam logic CONV_DONE_RST = 1'b1;

    // Sequencer states, Gray coded from ST_COARSE to ST_CONV along the asynchronous path
    typedef enum logic [2:0] {
        ST_COARSE = 3'h0,
        ST_FINE = 3'h1,
        ST_TRACKED = 3'h3,
        ST_ALIGN = 3'h2,
        ST_CONV = 3'h6
    } acs_state_t;

    // Control strobes arriving on pins from the far side
    typedef struct packed {
        logic chip_select_n;
        logic read_strobe_n;
        logic reg_select;
        logic sample_hold_n;
        logic bipolar_select;
        logic loopback_en;
    } acs_pins_t;

    localparam int unsigned PINS_W = $bits(acs_pins_t);

    // Reset value of synchronised pins: strobes idle high, modes low
    localparam acs_pins_t PINS_RST = '{
        chip_select_n: 1'b1,
        read_strobe_n: 1'b1,
        reg_select: 1'b0,
        sample_hold_n: 1'b1,
        bipolar_select: 1'b0,
        loopback_en: 1'b0
    };

    // Capacitor array switch settings shown to the analog side
    typedef struct packed {
        logic precharge;
        logic finecharge;
        logic hold;
        logic half_array;
    } acs_array_t;

endpackage

// File: rtl/acs_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module acs_sync
    import acs_pkg::*;
#(
    parameter int unsigned W = PINS_W,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Raw and filtered levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] agree;

    // Stage one feeds only stage two
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            dout <= RST_VAL;
        end else if (ce) begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            dout <= (agree & s2_q) | (~agree & dout);
        end
    end

    // A bit changes only once stages two and three agree
    assign agree = ~(s2_q ^ s3_q);

endmodule
`default_nettype wire

// File: rtl/acs_sar.sv
// Successive-approximation register; result coding is the same for both ranges
`timescale 1ns/1ps
`default_nettype none
module acs_sar
    import acs_pkg::*;
#(
    parameter int unsigned W = RES_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Control
    input wire logic start,
    input wire logic bipolar,
    input wire logic comp_above,
    // Results
    output logic [W-1:0] trial,
    output logic busy,
    output logic done,
    output logic [W-1:0] result
);

    logic [W-1:0] bit_q;
    logic [W-1:0] keep;
    logic last;

    // Comparator high keeps the bit under trial
    assign keep = comp_above ? trial : (trial & ~bit_q);
    assign last = bit_q[0];

    // One bit decided per cycle, MSB first
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_q <= '0;
            trial <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            result <= '0;
        end else if (ce) begin
            done <= 1'b0;
            if (start) begin
                bit_q <= {1'b1, {(W-1){1'b0}}};
                trial <= {1'b1, {(W-1){1'b0}}};
                busy <= 1'b1;
            end else if (busy) begin
                bit_q <= bit_q >> 1;
                trial <= (keep | (bit_q >> 1));
                if (last) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    // Same trial order serves both ranges: a code
                    // of all zeros is negative full scale either way
                    result <= keep;
                end
            end
        end
    end

endmodule
`default_nettype wire

// File: rtl/acs_top.sv
// Acquire, hold and convert sequencer for a calibrating SAR converter
// Behaviour
// - After conversion done falls: 6 coarse cycles, 9 fine cycles, then track done low.
// - First six tracking cycles pre-charge the array from the buffered input.
// - Afterwards the array fine-charges straight from the unbuffered input pin.
// - In loopback, falling track done drives hold low and captures the sample.
// - In loopback, conversion starts on the next master clock rising edge.
// - In asynchronous use, track done stays low until hold goes low.
// - Asynchronous hold captures at once; conversion may start up to four cycles later.
// - Track done returns high when conversion of the held sample begins.
// - Conversion done falls when a conversion completes and the result is valid.
// - Standalone strapping returns conversion done high four cycles after it falls.
// - Under processor control, conversion done rises within four cycles of a read.
// - Conversion done rises four cycles after hold low seen on a divide-by-four edge.
// - Bipolar select low gives unipolar range and straight binary results.
// - Bipolar select high gives bipolar range and offset-binary results.
// - Positive full scale reads all ones, negative full scale all zeros.
// - Bipolar select may change after calibration without recalibrating.
`timescale 1ns/1ps
`default_nettype none
module acs_top
    import acs_pkg::*;
#(
    parameter int unsigned RES_BITS = RES_W
) (
    // Clock, reset and clock enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Strobes and mode pins from the far side
    input wire acs_pins_t pins,
    // Comparator decision for the current trial
    input wire logic comp_above,
    // Handshake pins
    output logic track_done_n,
    output logic conversion_done_n,
    // Array switches and DAC trial code
    output acs_array_t array_sw,
    output logic [RES_BITS-1:0] dac_trial,
    // Status
    output logic tracking,
    output logic converting,
    // Result bus
    output logic [RES_BITS-1:0] data_out
);

    // Elaboration-time parameter check
    if (RES_BITS < 2 || RES_BITS > 32) begin : g_bad_width
        $error("RES_BITS must lie between 2 and 32");
    end

    localparam logic [CNT_W-1:0] COARSE_LAST = CNT_W'(COARSE_CYC - 1);
    localparam logic [CNT_W-1:0] FINE_LAST = CNT_W'(FINE_CYC - 1);
    localparam logic [CNT_W-1:0] EOC_LAST = CNT_W'(EOC_CYC - 1);
    localparam logic [1:0] DIV_LAST = 2'(HOLD_DIV - 1);

    // Counter wrap test used by the phase and strobe counters
    function automatic logic at_last(input logic [CNT_W-1:0] cnt,
                                     input logic [CNT_W-1:0] last);
        at_last = (cnt == last);
    endfunction

    // Registers
    acs_state_t state_q;
    acs_state_t state_d;
    logic [CNT_W-1:0] phase_q;
    logic [CNT_W-1:0] phase_d;
    logic [1:0] div_q;
    logic [CNT_W-1:0] eoc_cnt_q;
    logic eoc_run_q;
    logic track_done_n_q;
    logic conversion_done_n_q;
    logic hold_q;
    logic bip_conv_q;
    logic hold_seen_q;
    logic read_act_q;

    // Synchronised pin levels
    acs_pins_t pin_s;

    acs_sync #(
        .W(PINS_W),
        .RST_VAL(PINS_RST)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .din(pins),
        .dout(pin_s)
    );

    // SAR core
    logic sar_start;
    logic sar_busy;
    logic sar_done;
    logic [RES_BITS-1:0] sar_trial;
    logic [RES_BITS-1:0] sar_result;

    acs_sar #(
        .W(RES_BITS)
    ) u_sar (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .start(sar_start),
        .bipolar(bip_conv_q),
        .comp_above(comp_above),
        .trial(sar_trial),
        .busy(sar_busy),
        .done(sar_done),
        .result(sar_result)
    );

    // Decoded events
    wire coarse_end;
    wire fine_end;
    wire div_edge;
    wire hold_low;
    wire loopback;
    wire read_act;
    wire read_rise;
    wire hold_recog;
    wire conv_go;
    wire eoc_fire;

    assign coarse_end = (state_q == ST_COARSE) && at_last(phase_q, COARSE_LAST);
    assign fine_end = (state_q == ST_FINE) && at_last(phase_q, FINE_LAST);
    assign div_edge = (div_q == DIV_LAST);
    assign hold_low = ~pin_s.sample_hold_n;
    assign loopback = pin_s.loopback_en;

    // Data read: chip select and read low with data selected
    assign read_act = ~pin_s.chip_select_n & ~pin_s.read_strobe_n & pin_s.reg_select;
    assign read_rise = read_act & ~read_act_q;

    // Hold only counts when seen on a divide-by-four edge
    assign hold_recog = hold_low & div_edge;

    // Loopback starts on our own track done; async waits for the /4 edge
    assign conv_go = (state_q == ST_TRACKED && loopback)
                     || (state_q == ST_ALIGN && div_edge);
    assign sar_start = conv_go;

    // Conversion done rise: standalone level read, fresh read, or hold
    assign eoc_fire = ~conversion_done_n_q && ~eoc_run_q
                      && (read_act || read_rise || (hold_recog && ~hold_seen_q));

    // Next-state logic for the acquire/convert sequence
    always_comb begin
        state_d = state_q;
        phase_d = phase_q + CNT_W'(1);
        case (state_q)
            ST_COARSE: begin
                if (coarse_end) begin
                    state_d = ST_FINE;
                    phase_d = '0;
                end
            end
            ST_FINE: begin
                if (fine_end) begin
                    state_d = ST_TRACKED;
                    phase_d = '0;
                end
            end
            ST_TRACKED: begin
                phase_d = '0;
                if (loopback) begin
                    state_d = ST_CONV;
                end else if (hold_low) begin
                    state_d = ST_ALIGN;
                end
            end
            ST_ALIGN: begin
                phase_d = '0;
                if (div_edge) begin
                    state_d = ST_CONV;
                end
            end
            ST_CONV: begin
                phase_d = '0;
                if (sar_done) begin
                    state_d = ST_COARSE;
                end
            end
            default: begin
                state_d = ST_COARSE;
                phase_d = '0;
            end
        endcase
    end

    // State and phase counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_COARSE;
            phase_q <= '0;
        end else if (ce) begin
            state_q <= state_d;
            phase_q <= phase_d;
        end
    end

    // Free-running divide-by-four phase for hold recognition
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
        end else if (ce) begin
            div_q <= div_q + 2'h1;
        end
    end

    // Track done: low at end of fine charge, high as conversion begins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            track_done_n_q <= TRACK_DONE_RST;
        end else if (ce) begin
            if (conv_go) begin
                track_done_n_q <= 1'b1;
            end else if (fine_end) begin
                track_done_n_q <= 1'b0;
            end
        end
    end

    // Sample hold switch: opened by loopback or by the outside hold
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_q <= 1'b0;
        end else if (ce) begin
            if (sar_done) begin
                hold_q <= 1'b0;
            end else if (fine_end && loopback) begin
                hold_q <= 1'b1;
            end else if (state_q == ST_TRACKED && hold_low) begin
                hold_q <= 1'b1;
            end
        end
    end

    // Range latched at conversion start for the SAR only; array_sw.half_array follows the live pin and can change mid-conversion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bip_conv_q <= 1'b0;
        end else if (ce) begin
            if (conv_go) begin
                bip_conv_q <= pin_s.bipolar_select;
            end
        end
    end

    // Conversion done strobe and its four-cycle return timer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conversion_done_n_q <= CONV_DONE_RST;
            eoc_cnt_q <= '0;
            eoc_run_q <= 1'b0;
        end else if (ce) begin
            if (sar_done) begin
                conversion_done_n_q <= 1'b0;
                eoc_cnt_q <= '0;
                eoc_run_q <= 1'b0;
            end else if (conv_go) begin
                conversion_done_n_q <= 1'b1;
                eoc_run_q <= 1'b0;
            end else if (eoc_fire) begin
                eoc_run_q <= 1'b1;
                eoc_cnt_q <= CNT_W'(1);
            end else if (eoc_run_q) begin
                eoc_cnt_q <= eoc_cnt_q + CNT_W'(1);
                if (at_last(eoc_cnt_q, EOC_LAST)) begin
                    conversion_done_n_q <= 1'b1;
                    eoc_run_q <= 1'b0;
                end
            end
        end
    end

    // Edge memories for read and hold recognition
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            read_act_q <= 1'b0;
            hold_seen_q <= 1'b0;
        end else if (ce) begin
            read_act_q <= read_act;
            if (~hold_low) begin
                hold_seen_q <= 1'b0;
            end else if (hold_recog) begin
                hold_seen_q <= 1'b1;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            array_sw <= '0;
            tracking <= 1'b0;
            converting <= 1'b0;
            data_out <= '0;
        end else if (ce) begin
            array_sw.precharge <= (state_d == ST_COARSE);
            array_sw.finecharge <= (state_d == ST_FINE)
                                   || (state_d == ST_TRACKED);
            array_sw.hold <= hold_q;
            // Bipolar uses half the array on the input
            array_sw.half_array <= pin_s.bipolar_select;
            tracking <= (state_d == ST_COARSE) || (state_d == ST_FINE)
                        || (state_d == ST_TRACKED);
            // Raised on the start edge so it rises together with track done
            converting <= sar_start || sar_busy;
            // Result updated in the cycle conversion done falls
            if (sar_done) begin
                data_out <= sar_result;
            end
        end
    end

    // Trial code straight from the SAR flop: a second register here would
    // make the comparator judge the previous cycle's trial
    assign dac_trial = sar_trial;
    assign track_done_n = track_done_n_q;
    assign conversion_done_n = conversion_done_n_q;

endmodule
`default_nettype wire

// File: bench/acs_top_checker.sv
// Port-level timing checks for the acquire/convert sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_top_checker
    import acs_pkg::*;
#(
    parameter int unsigned RES_BITS = RES_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched ports
    input wire acs_pins_t pins,
    input wire logic track_done_n,
    input wire logic conversion_done_n,
    input wire acs_array_t array_sw,
    input wire logic converting,
    input wire logic [RES_BITS-1:0] data_out
);
    // Converting rises on the start edge; done falls a full SAR pass plus one later
    localparam int CV = RES_BITS + 1;
    logic [4:0] up_q;
    logic [4:0] fine_run_q;
    logic warm;
    logic alone;
    // First acquisition straddles reset release, so phase lengths skip it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            up_q <= 5'h00;
        end else if (!warm) begin
            up_q <= up_q + 5'h01;
        end
    end
    // Consecutive fine-charge cycles; a counter, since long repeats unroll badly
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fine_run_q <= 5'h00;
        end else if (array_sw.finecharge && !array_sw.precharge && track_done_n) begin
            fine_run_q <= (fine_run_q == 5'h1f) ? fine_run_q : fine_run_q + 5'h01;
        end else begin
            fine_run_q <= 5'h00;
        end
    end
    // Warm-up flag and standalone strapping
    assign warm = up_q == 5'h1f;
    assign alone = !pins.chip_select_n && !pins.read_strobe_n && pins.reg_select;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Acquisition steps
    sequence s_coarse;
        (array_sw.precharge && !array_sw.finecharge)[*6];
    endsequence
    sequence s_fine;
        (array_sw.finecharge && !array_sw.precharge && track_done_n);
    endsequence
    a_track_phases: assert property (warm && $rose(array_sw.precharge)
        |-> s_coarse ##1 s_fine ##9 !track_done_n) else $error("acquisition phases wrong");
    a_fine_len: assert property (warm && $fell(track_done_n)
        |-> fine_run_q == 5'(FINE_CYC)) else $error("fine charge length wrong");
    a_loop_start: assert property (pins.loopback_en && $fell(track_done_n)
        |=> converting && track_done_n) else $error("loopback start late");
    a_tdn_rise: assert property ($rose(track_done_n) |-> converting)
        else $error("track done rose without conversion");
    a_eoc_fall: assert property ($rose(converting) |-> ##CV $fell(conversion_done_n))
        else $error("conversion length wrong");
    a_data_cdn: assert property ($changed(data_out) |-> $fell(conversion_done_n))
        else $error("result changed off done");
    a_eoc_alone: assert property (alone && $fell(conversion_done_n)
        |-> ##1 (!conversion_done_n)[*3] ##1 conversion_done_n) else $error("standalone strobe");
    a_eoc_read: assert property (!conversion_done_n && $rose(pins.read_strobe_n)
        && !pins.chip_select_n && pins.reg_select |-> ##[1:10] conversion_done_n)
        else $error("done not cleared by read");
    a_async_wait: assert property (!pins.loopback_en && !track_done_n
        && pins.sample_hold_n |=> !track_done_n) else $error("track done left early");
    a_hold_cap: assert property (!pins.loopback_en && !track_done_n
        && $fell(pins.sample_hold_n) |-> ##[1:6] array_sw.hold ##[0:6] (converting
        && track_done_n)) else $error("hold capture late");
    a_hold_cdn: assert property (!conversion_done_n && $fell(pins.sample_hold_n)
        |-> ##[1:14] conversion_done_n) else $error("done not cleared by hold");
endmodule
`default_nettype wire

// File: bench/acs_far.sv
// Far-side model: hold timing logic and input comparator
`timescale 1ns/1ps
`default_nettype none
module acs_far
    import acs_pkg::*;
#(
    parameter int unsigned W = RES_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Mode controls from the bench
    input wire logic loop,
    input wire logic early,
    input wire logic [3:0] dly,
    input wire logic [W-1:0] level,
    // Device side
    input wire logic track_done_n,
    input wire logic conversion_done_n,
    input wire logic [W-1:0] dac_trial,
    output logic sample_hold_n,
    output logic comp_above
);
    logic hold_q;
    logic tdn_q;
    logic [3:0] cnt_q;
    // Hold goes low late (after dly) or early (on done); freed once conversion starts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_q <= 1'b1;
            tdn_q <= 1'b1;
            cnt_q <= 4'h0;
        end else begin
            tdn_q <= track_done_n;
            cnt_q <= track_done_n ? 4'h0 : cnt_q + 4'h1;
            if (track_done_n && !tdn_q) begin
                hold_q <= 1'b1;
            end else if ((!track_done_n && cnt_q == dly) || (early && !conversion_done_n)) begin
                hold_q <= 1'b0;
            end
        end
    end
    // Loopback wiring ties hold straight to end of track
    assign sample_hold_n = loop ? track_done_n : hold_q;
    // Ideal comparator, so the result must equal the held level
    assign comp_above = level >= dac_trial;
endmodule
`default_nettype wire

// File: bench/tb_adc_acquire_convert_sequencer.sv
// Self-checking bench for the acquire/convert sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] %0t ns: value mismatch", $time); end end
module tb_adc_acquire_convert_sequencer
    import acs_pkg::*;
;
    localparam int unsigned RB = 16;
    localparam int CDN = 0, TDN = 1, CONV = 2;
    logic clk = 1'b0, rst = 1'b1;
    logic cs_n = 1'b1, rd_n = 1'b1, rsel = 1'b0, bip = 1'b0, loop = 1'b0, early = 1'b0;
    logic [3:0] dly = 4'h5;
    logic [RB-1:0] level = '0;
    wire logic hold_n, comp;
    acs_pins_t pins_w;
    logic track_done_n, conversion_done_n, tracking, converting;
    acs_array_t array_sw;
    logic [RB-1:0] dac_trial, data_out;
    int error_cnt = 0, check_count = 0, cyc = 0, n;

    // Pin bundle, hold strobe from the far-side model
    assign pins_w = acs_pins_t'({cs_n, rd_n, rsel, hold_n, bip, loop});

    acs_top #(.RES_BITS(RB)) dut (.clk, .rst, .ce(1'b1), .pins(pins_w), .comp_above(comp),
        .track_done_n, .conversion_done_n, .array_sw, .dac_trial, .tracking, .converting,
        .data_out);
    acs_far #(.W(RB)) far (.clk, .rst, .loop, .early, .dly, .level, .track_done_n,
        .conversion_done_n, .dac_trial, .sample_hold_n(hold_n), .comp_above(comp));

    initial forever #20 clk = ~clk;

    // Cycle ceiling well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            final_report();
        end
    end

    task step;
        @(posedge clk);
        #1;
    endtask

    task do_reset;
        rst = 1'b1;
        repeat (16) step();
        rst = 1'b0;
    endtask

    function automatic logic pick(input int which);
        case (which)
            CDN: return conversion_done_n;
            TDN: return track_done_n;
            default: return converting;
        endcase
    endfunction

    // Bounded wait; n holds the cycles spent
    task wait_for(input int which, input logic lvl, input int lim);
        n = 0;
        while (pick(which) !== lvl && n < lim) begin
            step();
            n++;
        end
    endtask

    // Loopback strap with standalone read levels, then a range change
    task t_loop;
        loop = 1'b1; cs_n = 1'b0; rd_n = 1'b0; rsel = 1'b1; bip = 1'b0; level = 16'h1234;
        do_reset();
        wait_for(TDN, 1'b0, 200);
        wait_for(CDN, 1'b0, 200);
        `CHK(n, RB + 2)
        `CHK(data_out, 16'h1234)
        level = 16'hffff;
        wait_for(CDN, 1'b1, 20);
        `CHK(n, 4)
        wait_for(CONV, 1'b1, 40);
        bip = 1'b1;
        wait_for(CDN, 1'b0, 40);
        `CHK(data_out, 16'hffff)
        level = 16'h8001;
        wait_for(CDN, 1'b1, 20);
        wait_for(CDN, 1'b0, 60);
        `CHK(data_out, 16'h8001)
        `CHK(array_sw.half_array, 1'b1)
        $display("t_loop done");
    endtask

    // Processor control: done stays low until a data read
    task t_proc;
        loop = 1'b1; cs_n = 1'b0; rd_n = 1'b1; rsel = 1'b1; bip = 1'b0; level = 16'h0000;
        do_reset();
        wait_for(CDN, 1'b0, 200);
        `CHK(data_out, 16'h0000)
        repeat (4) step();
        `CHK(conversion_done_n, 1'b0)
        rd_n = 1'b0;
        repeat (2) step();
        rd_n = 1'b1;
        wait_for(CDN, 1'b1, 20);
        `CHK(n <= 8, 1'b1)
        $display("t_proc done");
    endtask

    // Asynchronous hold: end of track waits for the far side
    task t_async;
        loop = 1'b0; cs_n = 1'b1; rsel = 1'b0; early = 1'b0; dly = 4'h5; level = 16'h5a5a;
        do_reset();
        wait_for(TDN, 1'b0, 200);
        n = 0;
        while (converting !== 1'b1 && n < 30) begin
            `CHK(track_done_n, 1'b0)
            step();
            n++;
        end
        `CHK(track_done_n, 1'b1)
        `CHK(n > 6 && n <= 16, 1'b1)
        wait_for(CDN, 1'b0, 40);
        `CHK(data_out, 16'h5a5a)
        $display("t_async done");
    endtask

    // Hold taken low during tracking clears done but starts nothing early
    task t_early;
        early = 1'b1; dly = 4'h2; level = 16'h0ff0;
        do_reset();
        wait_for(CDN, 1'b0, 200);
        level = 16'h0001;
        wait_for(CDN, 1'b1, 20);
        `CHK(n <= 12, 1'b1)
        `CHK(tracking, 1'b1)
        `CHK(converting, 1'b0)
        wait_for(CDN, 1'b0, 60);
        `CHK(data_out, 16'h0001)
        $display("t_early done");
    endtask

    task final_report;
        $display("checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        t_loop();
        t_proc();
        t_async();
        t_early();
        final_report();
    end
endmodule

bind acs_top acs_top_checker #(.RES_BITS(RES_BITS)) u_chk (.clk, .rst, .pins,
    .track_done_n, .conversion_done_n, .array_sw, .converting, .data_out);
`default_nettype wire
